// ===== design/udr_regs.svh
// Constants for the full-speed default descriptor store.
// Assumes inclusion by bare name from the design files only.
`ifndef UDR_REGS_SVH
`define UDR_REGS_SVH

// Descriptor type codes carried in the request
`define UDR_TYPE_DEVICE     8'h01
`define UDR_TYPE_CONFIG     8'h02
`define UDR_TYPE_QUALIFIER  8'h06

// Descriptor lengths in bytes
`define UDR_DEV_LEN         8'h12
`define UDR_QUAL_LEN        8'h0a
`define UDR_CFG_TOTAL       8'hab
`define UDR_CFG_HELD        8'h22

// Store offsets of each descriptor
`define UDR_DEV_BASE        6'h00
`define UDR_QUAL_BASE       6'h12
`define UDR_CFG_BASE        6'h1c

// Control packet size and configuration value
`define UDR_PKT_MAX         7'h40
`define UDR_CFG_VALUE       8'h01

// Reset values
`define UDR_RST_BYTE        8'h00
`define UDR_RST_CFG         8'h00

`endif

// ===== design/udr_pkg.sv
// Types for the full-speed default descriptor store.
// Assumes the constants header is compiled alongside.
package udr_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    UDR_IDLE = 4'b0001,
    UDR_SEND = 4'b0010,
    UDR_WAIT = 4'b0100,
    UDR_HOLD = 4'b1000
  } udr_state_t;

  // Descriptor selected by a request
  typedef enum logic [2:0] {
    UDR_K_NONE = 3'b001,
    UDR_K_DEV  = 3'b010,
    UDR_K_QUAL = 3'b100
  } udr_kind_t;

  // Whole state of the sequencer
  typedef struct packed {
    udr_state_t st;
    logic       is_cfg;
    logic [5:0] base;
    logic [7:0] ofs;
    logic [7:0] rem;
    logic [6:0] pcnt;
    logic [7:0] data;
    logic       valid;
    logic       pend;
    logic       done;
    logic       zlp;
    logic       zlp_due;
    logic       stall;
    logic       cfg_ack;
    logic       cfg_stall;
    logic [7:0] cfg;
  } udr_state_reg_t;

endpackage : udr_pkg

// ===== design/udr_rom.sv
// Fixed byte store of the default full-speed descriptors.
// Assumes a combinational caller; bytes past the held part of
// the configuration set come from the outside store port.
`timescale 1ns/1ps
`include "udr_regs.svh"

module udr_rom #(
  parameter logic [15:0] VENDOR_ID   = 16'hf0f0, // Arbitrary value
  parameter logic [15:0] PRODUCT_ID  = 16'h0f0f, // Arbitrary value
  parameter logic [15:0] RELEASE_BCD = 16'h0000
) (
  // Lookup
  input  wire logic       is_cfg,
  input  wire logic [5:0] base,
  input  wire logic [7:0] ofs,
  output logic      [7:0] rd_byte,
  // Outside store for the rest of the configuration set
  output logic      [7:0] ext_addr,
  input  wire logic [7:0] ext_data
);

  ////////////////////////////////////////////////////////////////////
  // Stored bytes in ascending offset order
  function automatic logic [7:0] udr_byte(input logic [5:0] i);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      // Device descriptor
      6'h00: b = `UDR_DEV_LEN;              // R1
      6'h01: b = `UDR_TYPE_DEVICE;
      6'h02: b = 8'h00;                     // R5
      6'h03: b = 8'h02;                     // R5
      6'h04: b = 8'hff;                     // R3
      6'h05: b = 8'hff;                     // R3
      6'h06: b = 8'hff;                     // R3
      6'h07: b = 8'h40;                     // R3
      6'h08: b = VENDOR_ID[7:0];            // R4
      6'h09: b = VENDOR_ID[15:8];           // R4
      6'h0a: b = PRODUCT_ID[7:0];           // R4
      6'h0b: b = PRODUCT_ID[15:8];          // R4
      6'h0c: b = RELEASE_BCD[7:0];          // R6
      6'h0d: b = RELEASE_BCD[15:8];         // R6
      6'h0e: b = 8'h00;                     // R7
      6'h0f: b = 8'h00;                     // R7
      6'h10: b = 8'h00;                     // R7
      6'h11: b = 8'h01;                     // R7
      // Device qualifier
      6'h12: b = `UDR_QUAL_LEN;             // R8
      6'h13: b = `UDR_TYPE_QUALIFIER;       // R8
      6'h14: b = 8'h00;                     // R5
      6'h15: b = 8'h02;                     // R5
      6'h16: b = 8'hff;                     // R8
      6'h17: b = 8'hff;                     // R8
      6'h18: b = 8'hff;                     // R8
      6'h19: b = 8'h40;                     // R8
      6'h1a: b = 8'h01;                     // R8
      6'h1b: b = 8'h00;                     // R8
      // Configuration descriptor
      6'h1c: b = 8'h09;                     // R9
      6'h1d: b = `UDR_TYPE_CONFIG;          // R9
      6'h1e: b = `UDR_CFG_TOTAL;            // R9
      6'h1f: b = 8'h00;                     // R9
      6'h20: b = 8'h01;                     // R10
      6'h21: b = `UDR_CFG_VALUE;            // R10
      6'h22: b = 8'h00;                     // R10
      6'h23: b = 8'h80;                     // R10
      6'h24: b = 8'h32;                     // R10
      // Interface 0, alternate 0
      6'h25: b = 8'h09;                     // R12
      6'h26: b = 8'h04;                     // R12
      6'h27: b = 8'h00;                     // R12
      6'h28: b = 8'h00;                     // R12
      6'h29: b = 8'h00;                     // R12
      6'h2a: b = 8'hff;                     // R12
      6'h2b: b = 8'hff;                     // R12
      6'h2c: b = 8'hff;                     // R12
      6'h2d: b = 8'h00;                     // R12
      // Interface 0, alternate 1
      6'h2e: b = 8'h09;                     // R13
      6'h2f: b = 8'h04;                     // R13
      6'h30: b = 8'h00;                     // R13
      6'h31: b = 8'h01;                     // R13
      6'h32: b = 8'h06;                     // R13
      6'h33: b = 8'hff;                     // R13
      6'h34: b = 8'hff;                     // R13
      6'h35: b = 8'hff;                     // R13
      6'h36: b = 8'h00;                     // R13
      // First endpoint of alternate 1, bulk OUT 1
      6'h37: b = 8'h07;                     // R14
      6'h38: b = 8'h05;                     // R14
      6'h39: b = 8'h01;                     // R14
      6'h3a: b = 8'h02;                     // R14
      6'h3b: b = 8'h40;                     // R14
      6'h3c: b = 8'h00;                     // R14
      6'h3d: b = 8'h00;                     // R14
      default: b = 8'h00;
    endcase
    return b;
  endfunction : udr_byte

  ////////////////////////////////////////////////////////////////////
  // Held bytes first, outside store past the held part
  always_comb begin
    ext_addr = ofs;
    if (is_cfg && (ofs >= `UDR_CFG_HELD)) begin
      rd_byte = ext_data;                   // R17
    end else begin
      rd_byte = udr_byte(base + ofs[5:0]);  // R2
    end
  end

endmodule : udr_rom

// ===== design/udr_top.sv
// Default full-speed descriptor source for endpoint zero.
// Assumes the endpoint-zero request logic on the same clock
// decodes requests and moves bytes into control IN packets.
// Get descriptor requests made while busy are dropped without a sign.
// An empty closing packet is flagged, never produced.
//
// Functional notes
// R1 - Device descriptor request returns the 18-byte default, length first.
// R2 - Bytes leave in ascending offset order, as held in the store.
// R3 - Device class codes are FFh; endpoint zero packet size 64.
// R4 - Vendor ID at offsets 8-9, product ID at 10-11, low first.
// R5 - Device and qualifier both report version 2.00 as 00h, 02h.
// R6 - Offsets 12-13 carry a release number set outside this block.
// R7 - String indices all zero; one configuration reported.
// R8 - Ten-byte qualifier, type 06h, vendor codes, size 64, one config.
// R9 - Nine-byte configuration, type 02h, total length 171 as ABh 00h.
// R10 - One interface, value 01h, no string, 80h attributes, 32h power.
// R11 - Host selects the default configuration with value 1.
// R12 - Interface 0 alternate 0: type 04h, no endpoints, vendor codes.
// R13 - Interface 0 alternate 1: six endpoints, vendor codes.
// R14 - First endpoint: 7 bytes, type 05h, OUT 1, bulk, 64, interval 0.
// R15 - This set is served only while running at full speed.
// R16 - Return at most the requested length, in packets of up to 64.
// R17 - Configuration request returns the whole set up to total length.
`timescale 1ns/1ps
`include "udr_regs.svh"

module udr_top #(
  parameter logic [15:0] VENDOR_ID   = 16'hf0f0, // Arbitrary value
  parameter logic [15:0] PRODUCT_ID  = 16'h0f0f, // Arbitrary value
  parameter logic [15:0] RELEASE_BCD = 16'h0000
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Link speed
  input  wire logic        full_speed,
  // Get descriptor request
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_type,
  input  wire logic [15:0] req_len,
  output logic             req_busy,
  output logic             req_stall,
  // Byte stream toward the endpoint zero buffer
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_pkt_end,
  input  wire logic        tx_ready,
  input  wire logic        pkt_ack,
  output logic             xfer_done,
  output logic             xfer_zlp,
  // Set configuration request
  input  wire logic        cfg_set,
  input  wire logic [7:0]  cfg_value,
  output logic             cfg_ack,
  output logic             cfg_stall,
  output logic [7:0]       cfg_active,
  // Outside store for the rest of the configuration set
  output logic [7:0]       ext_addr,
  input  wire logic [7:0]  ext_data
);

  ////////////////////////////////////////////////////////////////////
  // Clip a request length to a descriptor length
  // Long asks are legal; the answer stops at the end
  function automatic logic [7:0] udr_clip(input logic [15:0] want,
                                          input logic [7:0]  have);
    logic [7:0] r;

    r = have;
    // Full-width compare, no truncation
    if (want < {8'h00, have}) begin
      r = want[7:0];
    end
    return r;
  endfunction : udr_clip

  // Short last packet missing: a zero-length packet must follow
  // Only when the data ends on a packet boundary
  // and the host asked for more than was sent
  function automatic logic udr_need_zlp(input logic [7:0]  n,
                                        input logic [15:0] want);
    // Multiple of 64, short of the ask
    return (n != 8'h00)
        && (n[5:0] == 6'h00)
        && ({8'h00, n} < want);
  endfunction : udr_need_zlp

  ////////////////////////////////////////////////////////////////////
  // State and store lookup
  // s_d is the next value, s_q the register
  udr_pkg::udr_state_reg_t s_q;
  udr_pkg::udr_state_reg_t s_d;
  // Lookup result and handshake terms
  logic [7:0]              rom_byte;
  logic                    taken;
  logic                    load;
  logic [7:0]              n_len;

  // Held bytes by base plus offset
  // ext_data must be valid in the same cycle
  udr_rom #(
    .VENDOR_ID   (VENDOR_ID),
    .PRODUCT_ID  (PRODUCT_ID),
    .RELEASE_BCD (RELEASE_BCD)
  ) u_rom (
    .is_cfg   (s_q.is_cfg),
    .base     (s_q.base),
    .ofs      (s_q.ofs),
    .rd_byte  (rom_byte),
    .ext_addr (ext_addr),
    .ext_data (ext_data)
  );

  ////////////////////////////////////////////////////////////////////
  // Handshake terms
  // A byte leaves on an edge with valid and ready
  assign taken = s_q.valid && tx_ready;

  // Refill an empty slot, or one just emptied
  // unless that byte closed a packet
  assign load  = (s_q.st == udr_pkg::UDR_SEND)
               && (s_q.rem != 8'h00)
               && (!s_q.valid || (taken && !s_q.pend));

  ////////////////////////////////////////////////////////////////////
  // Next state
  // Pulses fall to zero unless set below
  always_comb begin
    s_d           = s_q;

    s_d.done      = 1'b0;
    s_d.zlp       = 1'b0;
    s_d.stall     = 1'b0;
    s_d.cfg_ack   = 1'b0;
    s_d.cfg_stall = 1'b0;
    // Length chosen for this request
    n_len         = 8'h00;

    // Set configuration, 0 or the one default value
    // Taken in any state, stream unaffected
    // A refused value keeps the active one
    if (cfg_set) begin
      // 0 unconfigures, 1 selects the set
      if (cfg_value == `UDR_CFG_VALUE || cfg_value == 8'h00) begin
        s_d.cfg     = cfg_value;                       // R11
        s_d.cfg_ack = 1'b1;
      end else begin
        s_d.cfg_stall = 1'b1;
      end
    end

    // Descriptor sequencer
    case (s_q.st)
      udr_pkg::UDR_IDLE: begin
        // Busy is low here, so no request is lost
        if (req_valid) begin
          // Each request restarts offset and count
          s_d.ofs    = 8'h00;
          s_d.pcnt   = 7'h00;
          s_d.is_cfg = 1'b0;
          s_d.st     = udr_pkg::UDR_SEND;

          // Only the full-speed set is held
          if (!full_speed) begin
            s_d.stall = 1'b1;                          // R15
            s_d.st    = udr_pkg::UDR_IDLE;
          end else if (req_type == `UDR_TYPE_DEVICE) begin
            s_d.base = `UDR_DEV_BASE;                  // R1
            n_len    = udr_clip(req_len, `UDR_DEV_LEN);
          end else if (req_type == `UDR_TYPE_QUALIFIER) begin
            s_d.base = `UDR_QUAL_BASE;                 // R8
            n_len    = udr_clip(req_len, `UDR_QUAL_LEN);
          end else if (req_type == `UDR_TYPE_CONFIG) begin
            s_d.base   = `UDR_CFG_BASE;                // R17
            s_d.is_cfg = 1'b1;
            n_len      = udr_clip(req_len, `UDR_CFG_TOTAL);
          end else begin
            // Unknown type: refused
            s_d.stall = 1'b1;
            s_d.st    = udr_pkg::UDR_IDLE;
          end

          // Bytes left, already clipped
          s_d.rem     = n_len;                         // R16
          s_d.zlp_due = udr_need_zlp(n_len, req_len);

          // Zero length asked: finish with no data
          // Busy never rises for it
          if (s_d.st == udr_pkg::UDR_SEND && n_len == 8'h00) begin
            s_d.done = 1'b1;
            s_d.st   = udr_pkg::UDR_IDLE;
          end
        end
      end

      udr_pkg::UDR_SEND: begin
        // Bytes stream one per cycle
        // Retire the byte just taken
        if (taken) begin
          s_d.valid = 1'b0;
          // A taken end mark closes the packet
          if (s_q.pend) begin
            s_d.pend = 1'b0;
            s_d.pcnt = 7'h00;
            // Last packet ends the transfer
            if (s_q.rem == 8'h00) begin
              s_d.done = 1'b1;
              s_d.zlp  = s_q.zlp_due;
              s_d.st   = udr_pkg::UDR_IDLE;
            end else begin
              s_d.st = udr_pkg::UDR_WAIT;              // R16
            end
          end
        end

        // Fetch the next byte in store order
        // Store read at the current offset
        if (load) begin
          s_d.data  = rom_byte;                        // R2
          s_d.valid = 1'b1;
          s_d.ofs   = s_q.ofs + 8'h01;                 // R2
          s_d.rem   = s_q.rem - 8'h01;
          s_d.pcnt  = s_q.pcnt + 7'h01;
          // End mark on the last or 64th byte
          s_d.pend  = (s_q.rem == 8'h01)
                   || (s_q.pcnt == (`UDR_PKT_MAX - 7'h01)); // R16
        end
      end

      udr_pkg::UDR_WAIT: begin
        // Next packet once the host acknowledged this one
        // pkt_ack elsewhere is ignored
        if (pkt_ack) begin
          s_d.st = udr_pkg::UDR_SEND;
        end
      end

      udr_pkg::UDR_HOLD: begin
        // Spare code, never entered
        s_d.st = udr_pkg::UDR_IDLE;
      end

      default: begin
        // Bad one-hot code recovers
        s_d.st = udr_pkg::UDR_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  // Reset loads constants only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle, nothing held, unconfigured
      s_q.st        <= udr_pkg::UDR_IDLE;
      s_q.is_cfg    <= 1'b0;
      s_q.base      <= `UDR_DEV_BASE;
      // Counters and offset
      s_q.ofs       <= 8'h00;
      s_q.rem       <= 8'h00;
      s_q.pcnt      <= 7'h00;

      // Byte slot and pulses
      s_q.data      <= `UDR_RST_BYTE;
      s_q.valid     <= 1'b0;
      s_q.pend      <= 1'b0;
      s_q.done      <= 1'b0;
      s_q.zlp       <= 1'b0;
      s_q.zlp_due   <= 1'b0;
      s_q.stall     <= 1'b0;
      s_q.cfg_ack   <= 1'b0;
      s_q.cfg_stall <= 1'b0;
      // No configuration selected
      s_q.cfg       <= `UDR_RST_CFG;
    end else begin
      // Whole struct at once
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  // Registers only; busy is a state compare

  // Request side
  assign req_busy   = (s_q.st != udr_pkg::UDR_IDLE);
  assign req_stall  = s_q.stall;

  // Byte stream
  assign tx_valid   = s_q.valid;
  assign tx_data    = s_q.data;
  assign tx_pkt_end = s_q.pend;
  // One-cycle pulses
  assign xfer_done  = s_q.done;
  assign xfer_zlp   = s_q.zlp;

  // Configuration
  assign cfg_ack    = s_q.cfg_ack;
  assign cfg_stall  = s_q.cfg_stall;
  assign cfg_active = s_q.cfg;

endmodule : udr_top

// ===== testbench/udr_top_properties.sv
// Port assertions for the default descriptor source.
// Assumes it is bound onto udr_top, one clock domain.
`timescale 1ns/1ps
module udr_top_properties (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Request side
  input wire logic        full_speed,
  input wire logic        req_valid,
  input wire logic [7:0]  req_type,
  input wire logic [15:0] req_len,
  input wire logic        req_busy,
  input wire logic        req_stall,
  // Byte stream
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_pkt_end,
  input wire logic        tx_ready,
  input wire logic        xfer_done,
  input wire logic        xfer_zlp,
  // Configuration
  input wire logic        cfg_set,
  input wire logic [7:0]  cfg_value,
  input wire logic        cfg_ack,
  input wire logic        cfg_stall,
  input wire logic [7:0]  cfg_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic       take;
  logic       ok;
  logic [6:0] pcnt_q;
  assign take = req_valid && !req_busy;
  assign ok = take && full_speed && req_len != 16'h0000;
  // Bytes taken so far in the current packet
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) pcnt_q <= 7'h00;
    else if (!req_busy || (tx_valid && tx_ready && tx_pkt_end))
      pcnt_q <= 7'h00;
    else if (tx_valid && tx_ready) pcnt_q <= pcnt_q + 7'h01;
  end
  ////////////////////////////////////////////////////////////////////////
  AST_ANSWER: assert property (take |=> req_stall || xfer_done || req_busy)
    else $error("request left unanswered");
  AST_SPEED: assert property (take && !full_speed |=> req_stall && !req_busy)
    else $error("request served while not at full speed");
  AST_TYPE: assert property (take && !(req_type inside {8'h01, 8'h02, 8'h06})
    |=> req_stall) else $error("unknown type not refused");
  AST_DEV_HEAD: assert property (ok && req_type == 8'h01
    |=> ##1 tx_valid && tx_data == 8'h12) else $error("device head wrong");
  AST_QUAL_HEAD: assert property (ok && req_type == 8'h06
    |=> ##1 tx_valid && tx_data == 8'h0a) else $error("qualifier head wrong");
  AST_CFG_HEAD: assert property (ok && req_type == 8'h02
    |=> ##1 tx_valid && tx_data == 8'h09) else $error("config head wrong");
  AST_HOLD: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data) && $stable(tx_pkt_end))
    else $error("byte changed before taken");
  AST_PKT64: assert property (tx_valid && pcnt_q == 7'd63 |-> tx_pkt_end)
    else $error("packet longer than 64");
  AST_CFG_OK: assert property (cfg_set && cfg_value <= 8'h01
    |=> cfg_ack && !cfg_stall && cfg_active == $past(cfg_value))
    else $error("set configuration not accepted");
  AST_CFG_BAD: assert property (cfg_set && cfg_value > 8'h01
    |=> cfg_stall && !cfg_ack && $stable(cfg_active))
    else $error("bad configuration not refused");
  AST_ZLP: assert property (xfer_zlp |-> xfer_done)
    else $error("zero-length flag without done");
  // Main scenarios reached
  COV_DONE: cover property (xfer_done && !xfer_zlp);
  COV_ZLP: cover property (xfer_zlp);
  COV_STALL: cover property (req_stall);
  COV_CFG_STALL: cover property (cfg_stall);
endmodule : udr_top_properties

bind udr_top udr_top_properties i_udr_top_properties (
  .ref_clk(ref_clk), .rst_n(rst_n), .full_speed(full_speed),
  .req_valid(req_valid), .req_type(req_type), .req_len(req_len),
  .req_busy(req_busy), .req_stall(req_stall), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_pkt_end(tx_pkt_end), .tx_ready(tx_ready),
  .xfer_done(xfer_done), .xfer_zlp(xfer_zlp), .cfg_set(cfg_set),
  .cfg_value(cfg_value), .cfg_ack(cfg_ack), .cfg_stall(cfg_stall),
  .cfg_active(cfg_active));

// ===== testbench/udr_host_model.sv
// Endpoint-zero sink and outside store facing the descriptor source.
// Assumes the bench notes rx_cnt before each request.
`timescale 1ns/1ps
module udr_host_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Stall control from the bench
  input  wire logic       slow,
  // Byte stream
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_pkt_end,
  output logic            tx_ready,
  output logic            pkt_ack,
  // Outside store
  input  wire logic [7:0] ext_addr,
  output logic      [7:0] ext_data
);
  logic [7:0] rx_data [0:255];
  logic       rx_end  [0:255];
  int         rx_cnt;
  int         ack_dly;
  logic       tog;
  // Rest of the set: a pattern the bench can predict
  assign ext_data = ext_addr ^ 8'ha5;
  // Record bytes, stall every other cycle when slow, ack packets
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      pkt_ack <= 1'b0;
      ack_dly <= 0;
      tog <= 1'b0;
    end else begin
      tog <= !tog;
      tx_ready <= !slow || tog;
      pkt_ack <= (ack_dly == 1);
      if (ack_dly > 0) ack_dly <= ack_dly - 1;
      if (tx_valid && tx_ready) begin
        rx_data[rx_cnt[7:0]] <= tx_data;
        rx_end[rx_cnt[7:0]] <= tx_pkt_end;
        rx_cnt <= rx_cnt + 1;
        if (tx_pkt_end) ack_dly <= slow ? 6 : 1;
      end
    end
  end
endmodule : udr_host_model

// ===== testbench/testbench.sv
// Self-checking bench for the default descriptor source.
// Assumes udr_top, the checker and the host model are compiled.
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] VID = 16'h5a3c; // Arbitrary value
  localparam logic [15:0] PID = 16'hc35a; // Arbitrary value
  localparam logic [15:0] REL = 16'h0102;
  localparam logic [7:0] HELD [0:61] = '{
    8'h12, 8'h01, 8'h00, 8'h02, 8'hff, 8'hff, 8'hff, 8'h40, VID[7:0],
    VID[15:8], PID[7:0], PID[15:8], REL[7:0], REL[15:8], 8'h00, 8'h00,
    8'h00, 8'h01, 8'h0a, 8'h06, 8'h00, 8'h02, 8'hff, 8'hff, 8'hff,
    8'h40, 8'h01, 8'h00, 8'h09, 8'h02, 8'hab, 8'h00, 8'h01, 8'h01,
    8'h00, 8'h80, 8'h32, 8'h09, 8'h04, 8'h00, 8'h00, 8'h00, 8'hff,
    8'hff, 8'hff, 8'h00, 8'h09, 8'h04, 8'h00, 8'h01, 8'h06, 8'hff,
    8'hff, 8'hff, 8'h00, 8'h07, 8'h05, 8'h01, 8'h02, 8'h40, 8'h00,
    8'h00};
  logic        ref_clk, rst_n, full_speed, req_valid, req_busy, req_stall;
  logic        tx_valid, tx_pkt_end, tx_ready, pkt_ack, xfer_done;
  logic        xfer_zlp, cfg_set, cfg_ack, cfg_stall, slow;
  logic [7:0]  req_type, tx_data, cfg_value, cfg_active, ext_addr;
  logic [7:0]  ext_data;
  logic [15:0] req_len;
  int          failures = 0;
  int          total_checks = 0;

  udr_top #(.VENDOR_ID(VID), .PRODUCT_ID(PID), .RELEASE_BCD(REL)) i_udr_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .full_speed(full_speed),
    .req_valid(req_valid), .req_type(req_type), .req_len(req_len),
    .req_busy(req_busy), .req_stall(req_stall), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_pkt_end(tx_pkt_end), .tx_ready(tx_ready),
    .pkt_ack(pkt_ack), .xfer_done(xfer_done), .xfer_zlp(xfer_zlp),
    .cfg_set(cfg_set), .cfg_value(cfg_value), .cfg_ack(cfg_ack),
    .cfg_stall(cfg_stall), .cfg_active(cfg_active), .ext_addr(ext_addr),
    .ext_data(ext_data));
  udr_host_model i_udr_host_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_pkt_end(tx_pkt_end), .tx_ready(tx_ready),
    .pkt_ack(pkt_ack), .ext_addr(ext_addr), .ext_data(ext_data));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  function automatic logic [7:0] exp_byte(input logic [7:0] t, input int i);
    if (t == 8'h01) return HELD[i];
    if (t == 8'h06) return HELD[18+i];
    if (i < 34) return HELD[28+i];
    return 8'(i) ^ 8'ha5;
  endfunction : exp_byte

  // One descriptor request, then judge every byte the sink recorded
  task automatic run_req(input logic [7:0] t, input logic [15:0] len,
                         input int n, input logic zlp);
    int k;
    int c0;
    k = 0;
    c0 = i_udr_host_model.rx_cnt;
    @(posedge ref_clk);
    req_type <= t;
    req_len <= len;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    while (xfer_done !== 1'b1 && k < 2000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    check("done", {7'h0, xfer_done}, 8'h01);
    check("zlp", {7'h0, xfer_zlp}, {7'h0, zlp});
    check("busy", {7'h0, req_busy}, 8'h00);
    check("count", 8'(i_udr_host_model.rx_cnt - c0), 8'(n));
    for (int i = 0; i < n; i++) begin
      check("byte", i_udr_host_model.rx_data[8'(c0 + i)],
            exp_byte(t, i));
      check("pkt end", {7'h0, i_udr_host_model.rx_end[8'(c0 + i)]},
            {7'h0, (i % 64 == 63) || (i == n - 1)});
    end
  endtask : run_req

  // Request that must be refused with a stall pulse
  task automatic stall_req(input logic [7:0] t, input logic fs);
    @(posedge ref_clk);
    full_speed <= fs;
    req_type <= t;
    req_len <= 16'h0012;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    check("stall", {7'h0, req_stall}, 8'h01);
    @(posedge ref_clk);
    full_speed <= 1'b1;
  endtask : stall_req

  // Set configuration and judge the answer
  task automatic set_cfg(input logic [7:0] v, input logic good,
                         input logic [7:0] act);
    @(posedge ref_clk);
    cfg_set <= 1'b1;
    cfg_value <= v;
    @(posedge ref_clk);
    cfg_set <= 1'b0;
    #1;
    check("cfg ack", {7'h0, cfg_ack}, {7'h0, good});
    check("cfg stall", {7'h0, cfg_stall}, {7'h0, !good});
    check("cfg active", cfg_active, act);
  endtask : set_cfg

  task automatic t_descriptors;
    run_req(8'h01, 16'h0040, 18, 1'b0);
    run_req(8'h06, 16'h00ff, 10, 1'b0);
    slow = 1'b1;
    run_req(8'h02, 16'h00ff, 171, 1'b0);
    slow = 1'b0;
  endtask : t_descriptors

  task automatic t_lengths;
    run_req(8'h01, 16'h0008, 8, 1'b0);
    run_req(8'h02, 16'h0080, 128, 1'b0);
    run_req(8'h01, 16'h0000, 0, 1'b0);
  endtask : t_lengths

  task automatic t_refusals;
    stall_req(8'h03, 1'b1);
    stall_req(8'h01, 1'b0);
    set_cfg(8'h01, 1'b1, 8'h01);
    set_cfg(8'h02, 1'b0, 8'h01);
    set_cfg(8'h00, 1'b1, 8'h00);
  endtask : t_refusals

  // Clock at 200 MHz
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Watchdog on the whole run
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    finish_test();
  end
  // Reset, then scenarios
  initial begin
    {rst_n, req_valid, cfg_set, slow} = 4'h0;
    full_speed = 1'b1;
    req_type = 8'h00;
    req_len = 16'h0000;
    cfg_value = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_descriptors();
    t_lengths();
    t_refusals();
    finish_test();
  end
endmodule : testbench
